// *** rtl/fsirq_pkg.sv ***
// Purpose: constants for the fifo status and interrupt source bank
// Assumes: byte wide register port, one sample-rate domain
// Notes  : shared by the bank and its two helper modules
//
// Behaviour
// RULE1 - nonzero fifo mode: address 0x00 gives fifo status
// RULE2 - six-bit count of stored samples, resets zero
// RULE3 - overflow stays while overflowed, read keeps it
// RULE4 - watermark flag while count at or above watermark
// RULE5 - trigger mode: watermark position shows trigger
// RULE6 - status read clears fifo source, next sample resets
// RULE7 - trigger enables in bits 5..1 at 0x0A
// RULE8 - trigger mode: enabled event freezes fifo intake
// RULE9 - operating state 00 standby, 01 wake, 10 sleep
// RULE10 - gate error flag, cleared when fifo empties
// RULE11 - gate timer counts sample periods since error
// RULE12 - interrupt source flags at 0x0C, bits 7..0
// RULE13 - source read clears only vector-magnitude flag
// RULE14 - fifo status fields reset to zero
// RULE15 - fifo mode zero: address 0x00 gives sample status
// RULE16 - operating state read clears auto-sleep flag
// RULE17 - mode, watermark, flags and strobes are inputs
package fsirq_pkg;

    // ****************************************************
    // register map
    // ****************************************************
    localparam logic [7:0] ADDR_STATUS  = 8'h00;
    localparam logic [7:0] ADDR_TRIGCFG = 8'h0A;
    localparam logic [7:0] ADDR_OPSTATE = 8'h0B;
    localparam logic [7:0] ADDR_INTSRC  = 8'h0C;
    localparam logic [7:0] RST_BYTE     = 8'h00;
    localparam logic [7:0] TRIG_MASK    = 8'h3E;

    // ****************************************************
    // fields and encodings
    // ****************************************************
    localparam int         ST_OVF_BIT   = 7;
    localparam int         ST_WMRK_BIT  = 6;
    localparam int         SRC_ASLP     = 7;
    localparam int         SRC_FIFO     = 6;
    localparam int         SRC_VECM     = 1;
    localparam logic [5:0] FIFO_DEPTH   = 6'h20;
    localparam logic [5:0] CNT_RST      = 6'h00;
    localparam logic [4:0] FGT_MAX      = 5'h1F;
    localparam logic [1:0] MODE_OFF     = 2'h0;
    localparam logic [1:0] MODE_TRIG    = 2'h3;
    localparam logic [1:0] OPST_RST     = 2'h0;

    typedef enum logic {GATE_OPEN, GATE_SHUT} fsirq_gate_t;

endpackage : fsirq_pkg

// *** rtl/fsirq_fifo_track.sv ***
// Purpose: sample count and overflow flag of the fifo
// Assumes: push is an admitted sample, pop a sample read out
// Notes  : storage itself lives elsewhere
`timescale 1ns/1ps
module fsirq_fifo_track
    import fsirq_pkg::*;
(
    input  wire logic       mclk_i,
    input  wire logic       arst_n_i,
    input  wire logic       push_i,
    input  wire logic       pop_i,
    output logic      [5:0] cnt_o,
    output logic            ovf_o,
    output logic            empty_o
);
    logic [5:0] cnt_q;
    logic       ovf_q;
    logic       full;
    logic       inc;
    logic       dec;

    assign full    = (cnt_q == FIFO_DEPTH);
    assign inc     = push_i & (~full | pop_i);
    assign dec     = pop_i & (cnt_q != CNT_RST);
    assign cnt_o   = cnt_q;
    assign ovf_o   = ovf_q;
    assign empty_o = (cnt_q == CNT_RST);

    always_ff @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            cnt_q <= CNT_RST;                          // [RULE14]
        else
            cnt_q <= cnt_q + {5'h00, inc} - {5'h00, dec}; // [RULE2]
    end

    // overflow holds until room is made; a pop clears it even with a push in the same cycle
    always_ff @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            ovf_q <= 1'b0;                             // [RULE14]
        else if (push_i & full & ~pop_i)
            ovf_q <= 1'b1;                             // [RULE3]
        else if (pop_i)
            ovf_q <= 1'b0;
    end

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!arst_n_i);

    property p_cnt_range;
        cnt_q <= FIFO_DEPTH;
    endproperty
    a_cnt_range: assert property (p_cnt_range)     // [RULE2]
        else $error("fifo count above depth");

    property p_ovf_hold;
        ovf_q && !pop_i |=> ovf_q;
    endproperty
    a_ovf_hold: assert property (p_ovf_hold)       // [RULE3]
        else $error("overflow dropped while still overflowed");

endmodule : fsirq_fifo_track

// *** rtl/fsirq_gate_timer.sv ***
// Purpose: fifo gate error flag and its elapsed-period timer
// Assumes: tick_i pulses once per output sample period
// Notes  : timer stops at its top value instead of wrapping
`timescale 1ns/1ps
module fsirq_gate_timer
    import fsirq_pkg::*;
(
    input  wire logic       mclk_i,
    input  wire logic       arst_n_i,
    input  wire logic       err_i,
    input  wire logic       empty_i,
    input  wire logic       tick_i,
    output logic            fgerr_o,
    output logic      [4:0] fgt_o
);
    logic       fgerr_q;
    logic [4:0] fgt_q;

    assign fgerr_o = fgerr_q;
    assign fgt_o   = fgt_q;

    // a fresh error wins over the clear from an empty fifo
    always_ff @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            fgerr_q <= 1'b0;
        else if (err_i)
            fgerr_q <= 1'b1;                           // [RULE10]
        else if (empty_i)
            fgerr_q <= 1'b0;                           // [RULE10]
    end

    always_ff @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            fgt_q <= 5'h00;
        else if (!fgerr_q || (empty_i && !err_i))
            fgt_q <= 5'h00;                            // [RULE11]
        else if (tick_i && fgt_q != FGT_MAX)
            fgt_q <= fgt_q + 5'h01;                    // [RULE11]
    end

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!arst_n_i);

    property p_fgerr_clear;
        empty_i && !err_i |=> !fgerr_q ##1 (fgt_q == 5'h00);
    endproperty
    a_fgerr_clear: assert property (p_fgerr_clear)   // [RULE10]
        else $error("gate error not cleared on empty fifo");

    property p_fgt_count;
        fgerr_q && tick_i && !empty_i && fgt_q != FGT_MAX
            |=> fgt_q == $past(fgt_q) + 5'h01;
    endproperty
    a_fgt_count: assert property (p_fgt_count)       // [RULE11]
        else $error("gate timer missed a sample period");

endmodule : fsirq_gate_timer

// *** rtl/fsirq_top.sv ***
// Purpose: fifo status, trigger config, operating state, irq source
// Assumes: serial engine gives one-cycle read and write strobes
// Notes  : read data is registered one cycle after the strobe
`timescale 1ns/1ps
module fsirq_top
    import fsirq_pkg::*;
(
    input  wire logic       mclk_i,
    input  wire logic       arst_n_i,
    input  wire logic       rd_en_i,
    input  wire logic       wr_en_i,
    input  wire logic [7:0] addr_i,
    input  wire logic [7:0] wdata_i,
    output logic      [7:0] rdata_o,
    input  wire logic [1:0] fifo_mode_i,
    input  wire logic [5:0] wmrk_i,
    input  wire logic [7:0] sample_ready_status_i,
    input  wire logic       sample_push_i,
    input  wire logic       sample_pop_i,
    input  wire logic       odr_tick_i,
    input  wire logic       gate_err_i,
    input  wire logic [1:0] opstate_i,
    input  wire logic       ev_aslp_i,
    input  wire logic       ev_trans_i,
    input  wire logic       ev_lndprt_i,
    input  wire logic       ev_pulse_i,
    input  wire logic       ev_ffmt_i,
    input  wire logic       ev_vecm_i,
    input  wire logic       ev_drdy_i,
    input  wire logic       clr_trans_i,
    input  wire logic       clr_lndprt_i,
    input  wire logic       clr_pulse_i,
    input  wire logic       clr_ffmt_i,
    input  wire logic       clr_drdy_i,
    output logic            sample_admit_o,
    output logic            fifo_gated_o,
    output logic      [5:0] fifo_count_o,
    output logic      [7:0] int_source_o
);

    // ****************************************************
    // declarations
    // ****************************************************
    logic [7:0]  rdata_q;
    logic [7:0]  trig_cfg_q;
    logic [1:0]  opstate_q;
    logic [7:0]  src_q;
    logic [7:0]  src_set;
    logic [7:0]  src_clr;
    fsirq_gate_t gate_q;
    fsirq_gate_t gate_d;
    logic [5:0]  cnt;
    logic        ovf;
    logic        empty;
    logic        fgerr;
    logic [4:0]  fgt;
    logic        trig_mode;
    logic        fifo_on;
    logic        trig_hit;
    logic        admit;
    logic        wmrk_hit;
    logic        wmrk_bit;
    logic        fifo_set;
    logic [7:0]  status_byte;
    logic [7:0]  opstate_byte;
    logic        rd_status;
    logic        rd_opstate;
    logic        rd_intsrc;
    logic        wr_trigcfg;

    // ****************************************************
    // decode
    // ****************************************************
    assign rd_status  = rd_en_i & (addr_i == ADDR_STATUS);
    assign rd_opstate = rd_en_i & (addr_i == ADDR_OPSTATE);
    assign rd_intsrc  = rd_en_i & (addr_i == ADDR_INTSRC);
    assign wr_trigcfg = wr_en_i & (addr_i == ADDR_TRIGCFG);
    assign trig_mode  = (fifo_mode_i == MODE_TRIG);
    assign fifo_on    = (fifo_mode_i != MODE_OFF);     // [RULE17]

    // ****************************************************
    // trigger configuration
    // ****************************************************
    // unused bits are never stored, so they always read zero
    always_ff @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            trig_cfg_q <= RST_BYTE;                    // [RULE7]
        else if (wr_trigcfg)
            trig_cfg_q <= wdata_i & TRIG_MASK;         // [RULE7]
    end

    // ****************************************************
    // fifo gating in trigger mode
    // ****************************************************
    // enable bits 5..1 line up with source bits 5..1
    assign trig_hit = |(trig_cfg_q[5:1] & src_q[5:1]);

    always_comb
    begin
        gate_d = gate_q;
        case (gate_q)
            GATE_OPEN:
                if (trig_mode && trig_hit)
                    gate_d = GATE_SHUT;                // [RULE8]
            GATE_SHUT:
                if (!trig_mode)
                    gate_d = GATE_OPEN;
            default:
                gate_d = GATE_OPEN;
        endcase
    end

    always_ff @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            gate_q <= GATE_OPEN;
        else
            gate_q <= gate_d;
    end

    // the hit also blocks in its own cycle, so no late sample slips in
    assign admit = sample_push_i & (gate_q == GATE_OPEN)
                 & ~(trig_mode & trig_hit);            // [RULE8]
    assign sample_admit_o = admit;
    assign fifo_gated_o   = (gate_q == GATE_SHUT);

    // ****************************************************
    // fifo occupancy and gate error
    // ****************************************************
    fsirq_fifo_track u_track (
        .mclk_i   (mclk_i),
        .arst_n_i (arst_n_i),
        .push_i   (admit),
        .pop_i    (sample_pop_i),
        .cnt_o    (cnt),
        .ovf_o    (ovf),
        .empty_o  (empty)
    );

    fsirq_gate_timer u_gate (
        .mclk_i   (mclk_i),
        .arst_n_i (arst_n_i),
        .err_i    (gate_err_i),
        .empty_i  (empty),
        .tick_i   (odr_tick_i),
        .fgerr_o  (fgerr),
        .fgt_o    (fgt)
    );

    assign fifo_count_o = cnt;

    // ****************************************************
    // status byte
    // ****************************************************
    assign wmrk_hit = (cnt >= wmrk_i);                 // [RULE4]
    assign wmrk_bit = trig_mode ? (gate_q == GATE_SHUT)
                                : wmrk_hit;            // [RULE5]
    assign status_byte = {ovf, wmrk_bit, cnt};         // [RULE1]

    always_ff @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            opstate_q <= OPST_RST;
        else
            opstate_q <= opstate_i;                    // [RULE9]
    end

    assign opstate_byte = {fgerr, fgt, opstate_q};     // [RULE9]

    // ****************************************************
    // interrupt source flags
    // ****************************************************
    // fifo source rearms only on an admitted sample, or on any push while overflowed, during the event
    assign fifo_set = (admit | (sample_push_i & ovf))
                    & (ovf | wmrk_bit);                // [RULE6]

    assign src_set = {ev_aslp_i, fifo_set, ev_trans_i, ev_lndprt_i,
                      ev_pulse_i, ev_ffmt_i, ev_vecm_i, ev_drdy_i};
    assign src_clr = {rd_opstate,                      // [RULE16]
                      rd_status & fifo_on,             // [RULE6]
                      clr_trans_i, clr_lndprt_i,       // [RULE13]
                      clr_pulse_i, clr_ffmt_i,
                      rd_intsrc,                       // [RULE13]
                      clr_drdy_i};

    // a set in the clearing cycle is kept
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1)
        begin : g_src
            always_ff @(posedge mclk_i or negedge arst_n_i)
            begin
                if (!arst_n_i)
                    src_q[gi] <= 1'b0;
                else if (src_set[gi])
                    src_q[gi] <= 1'b1;                 // [RULE12]
                else if (src_clr[gi])
                    src_q[gi] <= 1'b0;
            end
        end
    endgenerate

    assign int_source_o = src_q;

    // ****************************************************
    // read port
    // ****************************************************
    always_ff @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            rdata_q <= RST_BYTE;
        else if (rd_en_i)
        begin
            case (addr_i)
                ADDR_STATUS:
                    if (fifo_on)
                        rdata_q <= status_byte;        // [RULE1]
                    else
                        rdata_q <= sample_ready_status_i; // [RULE15]
                ADDR_TRIGCFG:
                    rdata_q <= trig_cfg_q;
                ADDR_OPSTATE:
                    rdata_q <= opstate_byte;
                ADDR_INTSRC:
                    rdata_q <= src_q;                  // [RULE12]
                default:
                    rdata_q <= RST_BYTE;
            endcase
        end
    end

    assign rdata_o = rdata_q;

    // ****************************************************
    // checks
    // ****************************************************
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!arst_n_i);

    sequence s_status_rd;
        rd_en_i && addr_i == ADDR_STATUS;
    endsequence

    sequence s_gate_hit;
        trig_mode && trig_hit ##1 trig_mode;
    endsequence

    property p_fifo_view;
        s_status_rd and fifo_on |=> rdata_o == $past(status_byte);
    endproperty
    a_fifo_view: assert property (p_fifo_view)       // [RULE1]
        else $error("status address not showing fifo status");

    property p_ready_view;
        s_status_rd and !fifo_on
            |=> rdata_o == $past(sample_ready_status_i);
    endproperty
    a_ready_view: assert property (p_ready_view)     // [RULE15]
        else $error("status address not showing sample status");

    property p_fifo_src_clr;
        s_status_rd and fifo_on and !fifo_set |=> !src_q[SRC_FIFO];
    endproperty
    a_fifo_src_clr: assert property (p_fifo_src_clr) // [RULE6]
        else $error("status read left fifo source set");

    property p_intsrc_rd;
        rd_intsrc && !ev_vecm_i && src_q[5] && !clr_trans_i
            |=> !src_q[SRC_VECM] && src_q[5];
    endproperty
    a_intsrc_rd: assert property (p_intsrc_rd)       // [RULE13]
        else $error("source read cleared the wrong flags");

    property p_aslp_clr;
        rd_opstate && !ev_aslp_i |=> !src_q[SRC_ASLP];
    endproperty
    a_aslp_clr: assert property (p_aslp_clr)         // [RULE16]
        else $error("state read left auto-sleep flag set");

    property p_gate_block;
        s_gate_hit |-> !sample_admit_o ##1 (!trig_mode || fifo_gated_o);
    endproperty
    a_gate_block: assert property (p_gate_block)     // [RULE8]
        else $error("samples admitted after trigger event");

    property p_trig_cfg_wr;
        wr_trigcfg |=> trig_cfg_q == ($past(wdata_i) & TRIG_MASK);
    endproperty
    a_trig_cfg_wr: assert property (p_trig_cfg_wr)   // [RULE7]
        else $error("trigger config write not stored");

    property p_opstate_rd;
        rd_opstate |=> rdata_o[1:0] == $past(opstate_q)
                    && rdata_o[7] == $past(fgerr);
    endproperty
    a_opstate_rd: assert property (p_opstate_rd)     // [RULE9]
        else $error("operating state read wrong");

    property p_wmrk_flag;
        !trig_mode && cnt >= wmrk_i |-> status_byte[ST_WMRK_BIT];
    endproperty
    a_wmrk_flag: assert property (p_wmrk_flag)       // [RULE4]
        else $error("watermark flag missing");

    property p_trig_flag;
        trig_mode |-> status_byte[ST_WMRK_BIT] == fifo_gated_o;
    endproperty
    a_trig_flag: assert property (p_trig_flag)       // [RULE5]
        else $error("trigger flag does not follow gate");

    property p_ovf_bit;
        status_byte[ST_OVF_BIT] && !sample_pop_i
            |=> status_byte[ST_OVF_BIT];
    endproperty
    a_ovf_bit: assert property (p_ovf_bit)           // [RULE3]
        else $error("overflow bit dropped without room");

endmodule : fsirq_top

// *** testbench/fsirq_host.sv ***
// Purpose: host side of the byte register port
// Assumes: design takes strobes on the rising clock edge
// Notes  : address and data wander while no strobe is up
`timescale 1ns/1ps
module fsirq_host
(
    input  wire logic       mclk_i,
    input  wire logic [7:0] rdata_i,
    output logic            rd_en_o,
    output logic            wr_en_o,
    output logic      [7:0] addr_o,
    output logic      [7:0] wdata_o
);
    initial
    begin
        rd_en_o = 1'b0;
        wr_en_o = 1'b0;
        addr_o  = 8'hFF;
        wdata_o = 8'h55;
    end

    // inverted bus after release, so a stale address never looks valid
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk_i);
        wr_en_o = 1'b1;
        addr_o  = a;
        wdata_o = d;
        @(negedge mclk_i);
        wr_en_o = 1'b0;
        addr_o  = ~a;
        wdata_o = ~d;
    endtask : reg_wr

    // a status read in a nonzero fifo mode also drops the fifo source flag
    task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge mclk_i);
        rd_en_o = 1'b1;
        addr_o  = a;
        @(negedge mclk_i);
        rd_en_o = 1'b0;
        addr_o  = ~a;
        d       = rdata_i;
    endtask : reg_rd
endmodule : fsirq_host

// *** testbench/testbench.sv ***
// Purpose: self-checking bench for the status and source bank
// Assumes: inputs change on the falling clock edge
// Notes  : fifo contents are only counted, never stored
`timescale 1ns/1ps
module testbench
    import fsirq_pkg::*;
();
    logic       mclk, arst_n, rd_en, wr_en, push, pop, tick, gerr;
    logic       admit, gated;
    logic [7:0] addr, wdata, rdata, ev_v, clr_v, src;
    logic [1:0] fmode, opst;
    logic [5:0] wmrk, cnt;
    int         fails, checks;

    fsirq_host u_host (.mclk_i(mclk), .rdata_i(rdata), .rd_en_o(rd_en),
        .wr_en_o(wr_en), .addr_o(addr), .wdata_o(wdata));

    fsirq_top uut (.mclk_i(mclk), .arst_n_i(arst_n), .rd_en_i(rd_en),
        .wr_en_i(wr_en), .addr_i(addr), .wdata_i(wdata), .rdata_o(rdata),
        .fifo_mode_i(fmode), .wmrk_i(wmrk), .sample_ready_status_i(8'hA5),
        .sample_push_i(push), .sample_pop_i(pop), .odr_tick_i(tick),
        .gate_err_i(gerr), .opstate_i(opst), .ev_aslp_i(ev_v[7]),
        .ev_trans_i(ev_v[5]), .ev_lndprt_i(ev_v[4]), .ev_pulse_i(ev_v[3]),
        .ev_ffmt_i(ev_v[2]), .ev_vecm_i(ev_v[1]), .ev_drdy_i(ev_v[0]),
        .clr_trans_i(clr_v[5]), .clr_lndprt_i(clr_v[4]),
        .clr_pulse_i(clr_v[3]), .clr_ffmt_i(clr_v[2]),
        .clr_drdy_i(clr_v[0]), .sample_admit_o(admit),
        .fifo_gated_o(gated), .fifo_count_o(cnt), .int_source_o(src));

    // ****************************************************
    // tasks
    // ****************************************************
    task automatic close_out;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : close_out

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("unexpected at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask : chk

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] v;
        u_host.reg_rd(a, v);
        chk(v, exp);
    endtask : rd_chk

    task automatic fifo_op(input int n, input logic ps, input logic pp);
        repeat (n)
        begin
            @(negedge mclk);
            push = ps;
            pop  = pp;
            @(negedge mclk);
            push = 1'b0;
            pop  = 1'b0;
        end
    endtask : fifo_op

    task automatic strobe(input logic [7:0] e, input logic [7:0] c,
                          input logic t, input logic g);
        @(negedge mclk);
        ev_v  = e;
        clr_v = c;
        tick  = t;
        gerr  = g;
        @(negedge mclk);
        ev_v  = 8'h00;
        clr_v = 8'h00;
        tick  = 1'b0;
        gerr  = 1'b0;
    endtask : strobe

    // ****************************************************
    // tests
    // ****************************************************
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // whole run is well under a thousand cycles
    initial
    begin
        #100us;
        fails++;
        close_out();
    end

    initial
    begin
        logic [7:0] exp;
        int         bits [5] = '{5, 4, 3, 2, 0};
        fails  = 0;
        checks = 0;
        arst_n = 1'b0;
        {push, pop, tick, gerr} = 4'h0;
        ev_v   = 8'h00;
        clr_v  = 8'h00;
        fmode  = 2'h1;
        opst   = 2'h0;
        wmrk   = 6'h03;
        repeat (4) @(negedge mclk);
        chk({2'h0, cnt}, {2'h0, CNT_RST});
        arst_n = 1'b1;
        rd_chk(ADDR_STATUS, RST_BYTE);
        rd_chk(ADDR_TRIGCFG, RST_BYTE);
        rd_chk(ADDR_OPSTATE, RST_BYTE);
        rd_chk(ADDR_INTSRC, RST_BYTE);
        rd_chk(8'h0D, RST_BYTE);
        for (int i = 0; i < 3; i++)
        begin
            opst = i[1:0];
            rd_chk(ADDR_OPSTATE, {6'h00, opst});
        end
        fmode = MODE_OFF;
        rd_chk(ADDR_STATUS, 8'hA5);
        fmode = 2'h1;
        rd_chk(ADDR_STATUS, 8'h00);
        u_host.reg_wr(ADDR_TRIGCFG, 8'hFF);
        rd_chk(ADDR_TRIGCFG, TRIG_MASK);
        u_host.reg_wr(ADDR_TRIGCFG, 8'h00);
        strobe(8'hBF, 8'h00, 1'b0, 1'b0);
        rd_chk(ADDR_INTSRC, 8'hBF);
        rd_chk(ADDR_INTSRC, 8'hBD);
        rd_chk(ADDR_OPSTATE, 8'h02);
        rd_chk(ADDR_INTSRC, 8'h3D);
        exp = 8'h3D;
        foreach (bits[i])
        begin
            strobe(8'h00, 8'h01 << bits[i], 1'b0, 1'b0);
            exp[bits[i]] = 1'b0;
            chk(src, exp);
        end
        u_host.reg_wr(ADDR_INTSRC, 8'hFF);
        rd_chk(ADDR_INTSRC, 8'h00);
        fifo_op(2, 1'b1, 1'b0);
        rd_chk(ADDR_STATUS, 8'h02);
        rd_chk(ADDR_INTSRC, 8'h00);
        fifo_op(2, 1'b1, 1'b0);
        rd_chk(ADDR_INTSRC, 8'h40);
        rd_chk(ADDR_STATUS, 8'h44);
        rd_chk(ADDR_INTSRC, 8'h00);
        fifo_op(1, 1'b1, 1'b0);
        rd_chk(ADDR_INTSRC, 8'h40);
        wmrk = 6'h06;
        rd_chk(ADDR_STATUS, 8'h05);
        fifo_op(27, 1'b1, 1'b0);
        rd_chk(ADDR_STATUS, 8'h60);
        fifo_op(1, 1'b1, 1'b0);
        rd_chk(ADDR_STATUS, 8'hE0);
        rd_chk(ADDR_STATUS, 8'hE0);
        fifo_op(1, 1'b0, 1'b1);
        rd_chk(ADDR_STATUS, 8'h5F);
        strobe(8'h00, 8'h00, 1'b0, 1'b1);
        repeat (3) strobe(8'h00, 8'h00, 1'b1, 1'b0);
        rd_chk(ADDR_OPSTATE, 8'h8E);
        fifo_op(31, 1'b0, 1'b1);
        rd_chk(ADDR_OPSTATE, 8'h02);
        rd_chk(ADDR_STATUS, 8'h00);
        fmode = MODE_TRIG;
        u_host.reg_wr(ADDR_TRIGCFG, 8'h20);
        fifo_op(2, 1'b1, 1'b0);
        strobe(8'h08, 8'h00, 1'b0, 1'b0);
        chk({7'h00, gated}, 8'h00);
        rd_chk(ADDR_STATUS, 8'h02);
        strobe(8'h20, 8'h00, 1'b0, 1'b0);
        // gate state is registered, so it shuts one edge after the flag
        @(negedge mclk);
        chk({7'h00, gated}, 8'h01);
        @(negedge mclk);
        push = 1'b1;
        #1;
        chk({7'h00, admit}, 8'h00);
        @(negedge mclk);
        push = 1'b0;
        rd_chk(ADDR_STATUS, 8'h42);
        strobe(8'h00, 8'h20, 1'b0, 1'b0);
        fmode = 2'h1;
        repeat (2) @(negedge mclk);
        chk({7'h00, gated}, 8'h00);
        close_out();
    end
endmodule : testbench
